// ### rtl/pin_expander_pkg.sv
// constants for the sixteen-pin processor control expander register bank
// assumes a 32-bit AHB-Lite slave, one register to each aligned word
package pin_expander_pkg;

	// pins in each port
	localparam int PORT_WIDTH = 8;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0] PORT0_PIN_LEVELS_IDX    = 8'h0C;
	localparam logic [7:0] PORT1_PIN_LEVELS_IDX    = 8'h0D;
	localparam logic [7:0] PORT0_DRIVE_LEVELS_IDX  = 8'h0E;
	localparam logic [7:0] PORT1_DRIVE_LEVELS_IDX  = 8'h0F;
	localparam logic [7:0] PORT0_PIN_DIRECTION_IDX = 8'h10;
	localparam logic [7:0] PORT1_PIN_DIRECTION_IDX = 8'h11;

	// byte address of a register index
	localparam int ADDR_SHIFT = 2;

	// values after reset
	localparam logic [7:0] DRIVE_LEVELS_RESET  = 8'h00;
	localparam logic [7:0] PIN_DIRECTION_RESET = 8'h00;

	// port-1 input bits with no pin behind them read as zero
	localparam logic [7:0] PORT1_LEVEL_MASK = 8'h77;

	// port-1 bit 3 has no pin at all
	localparam int PORT1_RESERVED_BIT = 3;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// ### rtl/expander_port.sv
// one eight-pin port: drive level register, direction register and the
// sampled pin levels; pins are synchronous to hclk
`timescale 1ns/1ns
module expander_port
	import pin_expander_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	input  wire logic             drive_we,
	input  wire logic             dir_we,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe_n,
	output logic      [WIDTH-1:0] drive_q,
	output logic      [WIDTH-1:0] dir_q,
	output logic      [WIDTH-1:0] level_q
);

	// RULE_04 drive levels reset
	// RULE_07 drive levels reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_q <= WIDTH'(DRIVE_LEVELS_RESET);
		end else if (ce && drive_we) begin
			drive_q <= wdata;
		end
	end

	// RULE_09 direction reset zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_q <= WIDTH'(PIN_DIRECTION_RESET);
		end else if (ce && dir_we) begin
			dir_q <= wdata;
		end
	end

	// RULE_11 sample pins on every clock with ce high, whatever the direction
	// the pin is read even while driven, so software sees any contention
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_q <= '0;
		end else if (ce) begin
			level_q <= pin_in;
		end
	end

	// RULE_10 direction selects role
	// RULE_11 drive only outputs
	assign pin_out  = drive_q;
	assign pin_oe_n = ~dir_q;

endmodule

// ### rtl/pin_expander_regs.sv
// register bank of one sixteen-pin processor control expander
// assumes an ahb-lite master on hclk and pins synchronous to hclk;
// each pin except port-1 bit 7 is split into input, output and active-low output enable; that one has no input
//
// Overview of operation
// RULE_01: port-0 input register shows eight pin levels
// RULE_02: writes to input registers change nothing
// RULE_03: port-1 input: selects, timer-mux, resets
// RULE_04: port-0 output register resets to zero
// RULE_05: port-0 output bits follow fixed pin order
// RULE_06: output bits readable, writable, drive pins
// RULE_07: port-1 output register read/write, resets zero
// RULE_08: port-1 output bits order, bit 3 reserved
// RULE_09: port-0 direction register resets to zero
// RULE_10: direction bit zero input, one output
// RULE_11: pin driven only when set output
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
module pin_expander_regs
	import pin_expander_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	// only the low byte of hwdata is stored, whatever the size
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	// port 0 pins
	// bit 0: core clock select 0
	input  wire logic        core_clock_select_0_level,
	output logic             core_clock_select_0,
	output logic             core_clock_select_0_oe_n,
	// bit 1: core clock select 1
	input  wire logic        core_clock_select_1_level,
	output logic             core_clock_select_1,
	output logic             core_clock_select_1_oe_n,
	// bit 2: host out
	input  wire logic        host_out_level,
	output logic             host_out_drive,
	output logic             host_out_drive_oe_n,
	// bit 3: non-maskable interrupt
	input  wire logic        nonmaskable_irq_level,
	output logic             nonmaskable_irq_drive,
	output logic             nonmaskable_irq_drive_oe_n,
	// bit 4: local reset
	input  wire logic        local_reset_level,
	output logic             local_reset_drive,
	output logic             local_reset_drive_oe_n,
	// bit 5: local reset interrupt enable
	input  wire logic        local_reset_irq_enable_level,
	output logic             local_reset_irq_enable_drive,
	output logic             local_reset_irq_enable_drive_oe_n,
	// bit 6: boot complete
	input  wire logic        boot_done_level,
	output logic             boot_done_drive,
	output logic             boot_done_drive_oe_n,
	// bit 7: reset status
	input  wire logic        reset_status_level,
	output logic             reset_status_drive,
	output logic             reset_status_drive_oe_n,
	// port 1 pins
	// bit 0: core select 0
	input  wire logic        core_select_0_level,
	output logic             core_select_0_drive,
	output logic             core_select_0_drive_oe_n,
	// bit 1: core select 1
	input  wire logic        core_select_1_level,
	output logic             core_select_1_drive,
	output logic             core_select_1_drive_oe_n,
	// bit 2: core select 2
	input  wire logic        core_select_2_level,
	output logic             core_select_2_drive,
	output logic             core_select_2_drive_oe_n,
	// bit 4: timer mux output enable
	input  wire logic        timer_mux_oe_level,
	output logic             timer_mux_oe_drive,
	output logic             timer_mux_oe_drive_oe_n,
	// bit 5: full reset
	input  wire logic        full_reset_level,
	output logic             full_reset_drive,
	output logic             full_reset_drive_oe_n,
	// bit 6: warm reset
	input  wire logic        warm_reset_level,
	output logic             warm_reset_drive,
	output logic             warm_reset_drive_oe_n,
	// bit 7: power-on reset, drive only
	output logic             power_on_reset_drive,
	output logic             power_on_reset_drive_oe_n
);

	// true when a word address hits a register index
	function automatic logic reg_hit(input logic [31:0] addr,
		input logic [7:0] idx);
		reg_hit = (addr == (32'(idx) << ADDR_SHIFT));
	endfunction

	// bus side state
	logic        addr_valid;
	logic        wr_pend_q;
	logic [31:0] wr_addr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0]  wbyte;

	// port 0 pin vectors and register copies
	logic [7:0]  p0_pin_in;
	logic [7:0]  p0_pin_out;
	logic [7:0]  p0_pin_oe_n;
	logic [7:0]  p0_drive;
	logic [7:0]  p0_dir;
	logic [7:0]  p0_level;

	// port 1 pin vectors and register copies
	logic [7:0]  p1_pin_in;
	logic [7:0]  p1_pin_out;
	logic [7:0]  p1_pin_oe_n;
	logic [7:0]  p1_drive;
	logic [7:0]  p1_dir;
	logic [7:0]  p1_level;

	// address phase is taken on any nonseq or seq while the bus is ready;
	// a frozen block holds hready low so no transfer is half done
	assign addr_valid = hsel && hready && ce &&
		(htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign hreadyout  = ce;

	// no access can fail, so every answer is okay
	assign hresp      = HRESP_OKAY;
	assign hrdata     = rdata_q;
	assign wbyte      = hwdata[7:0];

	// write decode on the registered address, during the data phase
	// RULE_02 inputs ignore writes
	logic wr_p0_drive;
	logic wr_p1_drive;
	logic wr_p0_dir;
	logic wr_p1_dir;
	assign wr_p0_drive = wr_pend_q && reg_hit(wr_addr_q, PORT0_DRIVE_LEVELS_IDX);
	assign wr_p1_drive = wr_pend_q && reg_hit(wr_addr_q, PORT1_DRIVE_LEVELS_IDX);
	assign wr_p0_dir   = wr_pend_q && reg_hit(wr_addr_q, PORT0_PIN_DIRECTION_IDX);
	assign wr_p1_dir   = wr_pend_q && reg_hit(wr_addr_q, PORT1_PIN_DIRECTION_IDX);

	// read selection; unmapped addresses read zero
	// RULE_01 port-0 levels readback
	// RULE_03 port-1 levels readback
	// RULE_06 drive bits read back
	always_comb begin
		rdata_d = '0;
		if (reg_hit(haddr, PORT0_PIN_LEVELS_IDX)) begin
			rdata_d[7:0] = p0_level;
		end else if (reg_hit(haddr, PORT1_PIN_LEVELS_IDX)) begin
			rdata_d[7:0] = p1_level & PORT1_LEVEL_MASK;
		end else if (reg_hit(haddr, PORT0_DRIVE_LEVELS_IDX)) begin
			rdata_d[7:0] = p0_drive;
		end else if (reg_hit(haddr, PORT1_DRIVE_LEVELS_IDX)) begin
			rdata_d[7:0] = p1_drive;
		end else if (reg_hit(haddr, PORT0_PIN_DIRECTION_IDX)) begin
			rdata_d[7:0] = p0_dir;
		end else if (reg_hit(haddr, PORT1_PIN_DIRECTION_IDX)) begin
			rdata_d[7:0] = p1_dir;
		end
	end

	// read data is captured in the address phase and stands in the data
	// phase, so a read costs no wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= '0;
		end else if (addr_valid && !hwrite) begin
			rdata_q <= rdata_d;
		end
	end

	// write address held for the data phase, when hwdata stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (ce) begin
			wr_pend_q <= addr_valid && hwrite;
			if (addr_valid && hwrite) begin
				wr_addr_q <= haddr;
			end
		end
	end

	// RULE_01 port-0 pin sampling
	// RULE_05 port-0 bit order
	assign p0_pin_in = {reset_status_level, boot_done_level,
		local_reset_irq_enable_level, local_reset_level,
		nonmaskable_irq_level, host_out_level,
		core_clock_select_1_level, core_clock_select_0_level};

	// RULE_03 port-1 pin sampling
	// bit 3 has no pin and bit 7 is drive only
	assign p1_pin_in = {1'b0, warm_reset_level, full_reset_level,
		timer_mux_oe_level, 1'b0, core_select_2_level,
		core_select_1_level, core_select_0_level};

	// RULE_06 writes drive pins
	expander_port #(
		.WIDTH (PORT_WIDTH)
	) u_port0 (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ce       (ce),
		.drive_we (wr_p0_drive),
		.dir_we   (wr_p0_dir),
		.wdata    (wbyte),
		.pin_in   (p0_pin_in),
		.pin_out  (p0_pin_out),
		.pin_oe_n (p0_pin_oe_n),
		.drive_q  (p0_drive),
		.dir_q    (p0_dir),
		.level_q  (p0_level)
	);

	expander_port #(
		.WIDTH (PORT_WIDTH)
	) u_port1 (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ce       (ce),
		.drive_we (wr_p1_drive),
		.dir_we   (wr_p1_dir),
		.wdata    (wbyte),
		.pin_in   (p1_pin_in),
		.pin_out  (p1_pin_out),
		.pin_oe_n (p1_pin_oe_n),
		.drive_q  (p1_drive),
		.dir_q    (p1_dir),
		.level_q  (p1_level)
	);

	// bit 0: core clock select 0
	// RULE_05 port-0 pin mapping
	assign core_clock_select_0               = p0_pin_out[0];
	assign core_clock_select_0_oe_n          = p0_pin_oe_n[0];

	// bit 1: core clock select 1
	assign core_clock_select_1               = p0_pin_out[1];
	assign core_clock_select_1_oe_n          = p0_pin_oe_n[1];

	// bit 2: host out
	assign host_out_drive                    = p0_pin_out[2];
	assign host_out_drive_oe_n               = p0_pin_oe_n[2];

	// bit 3: non-maskable interrupt
	assign nonmaskable_irq_drive             = p0_pin_out[3];
	assign nonmaskable_irq_drive_oe_n        = p0_pin_oe_n[3];

	// bit 4: local reset
	assign local_reset_drive                 = p0_pin_out[4];
	assign local_reset_drive_oe_n            = p0_pin_oe_n[4];

	// bit 5: local reset interrupt enable
	assign local_reset_irq_enable_drive      = p0_pin_out[5];
	assign local_reset_irq_enable_drive_oe_n = p0_pin_oe_n[5];

	// bit 6: boot complete
	assign boot_done_drive                   = p0_pin_out[6];
	assign boot_done_drive_oe_n              = p0_pin_oe_n[6];

	// bit 7: reset status
	assign reset_status_drive                = p0_pin_out[7];
	assign reset_status_drive_oe_n           = p0_pin_oe_n[7];

	// bit 3 keeps what software writes but reaches no pin
	// bit 0: core select 0
	// RULE_08 port-1 pin mapping
	assign core_select_0_drive       = p1_pin_out[0];
	assign core_select_0_drive_oe_n  = p1_pin_oe_n[0];

	// bit 1: core select 1
	assign core_select_1_drive       = p1_pin_out[1];
	assign core_select_1_drive_oe_n  = p1_pin_oe_n[1];

	// bit 2: core select 2
	assign core_select_2_drive       = p1_pin_out[2];
	assign core_select_2_drive_oe_n  = p1_pin_oe_n[2];

	// bit 4: timer mux output enable
	assign timer_mux_oe_drive        = p1_pin_out[4];
	assign timer_mux_oe_drive_oe_n   = p1_pin_oe_n[4];

	// bit 5: full reset
	assign full_reset_drive          = p1_pin_out[5];
	assign full_reset_drive_oe_n     = p1_pin_oe_n[5];

	// bit 6: warm reset
	assign warm_reset_drive          = p1_pin_out[6];
	assign warm_reset_drive_oe_n     = p1_pin_oe_n[6];

	// bit 7: power-on reset, no level input behind it
	assign power_on_reset_drive      = p1_pin_out[7];
	assign power_on_reset_drive_oe_n = p1_pin_oe_n[7];

endmodule

// ### verif/pin_expander_properties.sv
// assertions on the expander register bank, seeing only its top ports
// assumes one ahb-lite master with hready looped back from hreadyout
`timescale 1ns/1ns
module pin_expander_properties
	import pin_expander_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] haddr,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic [1:0]  htrans,
	input wire logic        hresp,
	input wire logic        core_clock_select_0_level,
	input wire logic        core_clock_select_0,
	input wire logic        core_clock_select_0_oe_n,
	input wire logic        power_on_reset_drive
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// address phase taken at this edge
	wire taken = hsel && hready && ce && htrans[1];
	// write taken, then its data phase completes at the next edge
	sequence s_wr(logic [31:0] a);
		taken && hwrite && haddr == a ##1 ce;
	endsequence
	sequence s_rd(logic [31:0] a);
		taken && !hwrite && haddr == a;
	endsequence
	property p_okay; hresp == HRESP_OKAY; endproperty
	a_okay: assert property (p_okay)
		else $error("response not okay");
	property p_rst; $rose(hresetn) |-> !core_clock_select_0 &&
		core_clock_select_0_oe_n && !power_on_reset_drive; endproperty
	a_rst: assert property (p_rst)
		else $error("pins not at reset state");
	property p_drv0; s_wr(32'h38) |=>
		core_clock_select_0 == $past(hwdata[0]); endproperty
	a_drv0: assert property (p_drv0)
		else $error("port0 pin level not written");
	property p_dir0; s_wr(32'h40) |=>
		core_clock_select_0_oe_n == !$past(hwdata[0]); endproperty
	a_dir0: assert property (p_dir0)
		else $error("port0 direction not applied");
	property p_drv1; s_wr(32'h3C) |=>
		power_on_reset_drive == $past(hwdata[7]); endproperty
	a_drv1: assert property (p_drv1)
		else $error("port1 bit 7 pin not written");
	property p_ro; s_wr(32'h30) |=> $stable(core_clock_select_0) &&
		$stable(core_clock_select_0_oe_n); endproperty
	a_ro: assert property (p_ro)
		else $error("input register write moved a pin");
	// level seen two edges before the answer is what the read returns
	property p_lvl; s_rd(32'h30) ##0 ($past(ce) && $past(hresetn)) |=>
		hrdata[0] == $past(core_clock_select_0_level, 2); endproperty
	a_lvl: assert property (p_lvl)
		else $error("port0 level read wrong");
	property p_res; s_rd(32'h34) |=> hrdata[31:8] == 24'h0 &&
		!hrdata[3] && !hrdata[7]; endproperty
	a_res: assert property (p_res)
		else $error("port1 reserved bits not zero");
endmodule

bind pin_expander_regs pin_expander_properties u_pin_expander_properties (
	.hclk, .hresetn, .ce, .hsel, .hwrite, .hready, .haddr, .hwdata,
	.hrdata, .htrans, .hresp, .core_clock_select_0_level,
	.core_clock_select_0, .core_clock_select_0_oe_n, .power_on_reset_drive
);

// ### verif/processor_pins.sv
// processor-side pins: a floating pin shows the board's own level
// assumes vectors in port bit order and active-low output enables
`timescale 1ns/1ns
module processor_pins (
	input  wire logic [7:0] drv0,
	input  wire logic [7:0] oen0,
	input  wire logic [7:0] drv1,
	input  wire logic [7:0] oen1,
	input  wire logic [7:0] own0,
	input  wire logic [7:0] own1,
	output logic      [7:0] lvl0,
	output logic      [7:0] lvl1
);
	assign lvl0 = (oen0 & own0) | (~oen0 & drv0);
	assign lvl1 = (oen1 & own1) | (~oen1 & drv1);
endmodule

// ### verif/soc_control_pin_expander_regs_tb.sv
// self-checking bench for the expander register bank over ahb-lite
// assumes the processor pin model and the bound property checker
`timescale 1ns/1ns
module soc_control_pin_expander_regs_tb import pin_expander_pkg::*;;
	logic        hclk, hresetn, ce, hwrite;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, rd;
	logic [7:0]  own0, own1, v, dir;
	wire  logic  hreadyout;
	wire  logic [31:0] hrdata;
	wire  logic [7:0]  l0, l1, d0, e0, d1, e1;
	int          err_count, checks, seed, i;
	pin_expander_regs u_pin_expander_regs (
		.hclk, .hresetn, .ce, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
		.hresp(), .core_clock_select_0_level(l0[0]),
		.core_clock_select_0(d0[0]), .core_clock_select_0_oe_n(e0[0]),
		.core_clock_select_1_level(l0[1]), .core_clock_select_1(d0[1]),
		.core_clock_select_1_oe_n(e0[1]), .host_out_level(l0[2]),
		.host_out_drive(d0[2]), .host_out_drive_oe_n(e0[2]),
		.nonmaskable_irq_level(l0[3]), .nonmaskable_irq_drive(d0[3]),
		.nonmaskable_irq_drive_oe_n(e0[3]), .local_reset_level(l0[4]),
		.local_reset_drive(d0[4]), .local_reset_drive_oe_n(e0[4]),
		.local_reset_irq_enable_level(l0[5]),
		.local_reset_irq_enable_drive(d0[5]),
		.local_reset_irq_enable_drive_oe_n(e0[5]),
		.boot_done_level(l0[6]), .boot_done_drive(d0[6]),
		.boot_done_drive_oe_n(e0[6]), .reset_status_level(l0[7]),
		.reset_status_drive(d0[7]), .reset_status_drive_oe_n(e0[7]),
		.core_select_0_level(l1[0]), .core_select_0_drive(d1[0]),
		.core_select_0_drive_oe_n(e1[0]), .core_select_1_level(l1[1]),
		.core_select_1_drive(d1[1]), .core_select_1_drive_oe_n(e1[1]),
		.core_select_2_level(l1[2]), .core_select_2_drive(d1[2]),
		.core_select_2_drive_oe_n(e1[2]), .timer_mux_oe_level(l1[4]),
		.timer_mux_oe_drive(d1[4]), .timer_mux_oe_drive_oe_n(e1[4]),
		.full_reset_level(l1[5]), .full_reset_drive(d1[5]),
		.full_reset_drive_oe_n(e1[5]), .warm_reset_level(l1[6]),
		.warm_reset_drive(d1[6]), .warm_reset_drive_oe_n(e1[6]),
		.power_on_reset_drive(d1[7]), .power_on_reset_drive_oe_n(e1[7])
	);
	processor_pins u_processor_pins (
		.drv0(d0), .oen0(e0), .drv1(d1), .oen1(e1), .own0(own0),
		.own1(own1), .lvl0(l0), .lvl1(l1)
	);
	// port 1 bit 3 has no pin; the model sees it floating
	assign d1[3] = 1'b0;
	assign e1[3] = 1'b1;
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// expected pin level: driven bits from the drive value, others floating
	function logic [7:0] lvl(input logic [7:0] dr, dv, fl);
		return (dr & dv) | (~dr & fl);
	endfunction
	task check(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// bounded wait for hready; a hang ends the run
	task waitrdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			err_count++;
			conclude();
		end
	endtask
	// single transfer; upper data bits are junk that must be ignored
	task ahb(input logic w, input logic [7:0] idx, d);
		haddr <= {22'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		waitrdy();
		htrans <= 2'h0;
		hwdata <= {24'hFFFFFF, d};
		waitrdy();
		rd = hrdata;
	endtask
	initial begin
		seed = 10769;
		err_count = 0;
		checks = 0;
		hresetn = 1'b0;
		ce = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		own0 = 8'h00;
		own1 = 8'h00;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 4; i++) begin
			ahb(1'b0, PORT0_DRIVE_LEVELS_IDX + 8'(i), 8'h00);
			check("reset value", rd, 32'h0);
		end
		check("reset oe_n", e0, 8'hFF);
		$display("test reset done");
		for (i = 0; i < 16; i++) begin
			own0 <= 8'($random(seed));
			own1 <= 8'($random(seed));
			v = (i < 2) ? {8{i[0]}} : 8'($random(seed));
			dir = (i < 2) ? ~v : 8'($random(seed));
			// odd passes stall the write with the clock enable low
			ce <= ~i[0];
			fork
				ahb(1'b1, PORT0_DRIVE_LEVELS_IDX, v);
				begin
					repeat (3) @(posedge hclk);
					ce <= 1'b1;
				end
			join
			ahb(1'b1, PORT0_PIN_DIRECTION_IDX, dir);
			ahb(1'b0, PORT0_DRIVE_LEVELS_IDX, 8'h00);
			check("p0 readback", rd, {24'h0, v});
			check("p0 pins", d0, v);
			check("p0 oe_n", e0, 8'(~dir));
			repeat (2) @(posedge hclk);
			ahb(1'b0, PORT0_PIN_LEVELS_IDX, 8'h00);
			check("p0 levels", rd, lvl(dir, v, own0));
			ahb(1'b1, PORT1_DRIVE_LEVELS_IDX, v);
			ahb(1'b1, PORT1_PIN_DIRECTION_IDX, dir);
			ahb(1'b0, PORT1_DRIVE_LEVELS_IDX, 8'h00);
			check("p1 readback", rd, {24'h0, v});
			check("p1 pins", d1 & 8'hF7, v & 8'hF7);
			check("p1 oe_n", e1 & 8'hF7, ~dir & 8'hF7);
			// let the level register sample the pins after the new direction
			repeat (2) @(posedge hclk);
			ahb(1'b0, PORT1_PIN_LEVELS_IDX, 8'h00);
			check("p1 levels", rd, lvl(dir, v, own1) & 8'h77);
			ahb(1'b1, PORT0_PIN_LEVELS_IDX, ~v);
			ahb(1'b1, PORT1_PIN_LEVELS_IDX, ~v);
			ahb(1'b0, PORT0_PIN_LEVELS_IDX, 8'h00);
			check("ro levels", rd, lvl(dir, v, own0));
			check("ro pins", {d1 & 8'hF7, e0, d0},
				{v & 8'hF7, 8'(~dir), v});
		end
		$display("test random traffic done");
		ahb(1'b1, 8'h12, 8'hFF);
		ahb(1'b0, 8'h12, 8'h00);
		check("unmapped", rd, 32'h0);
		// second reset in mid-run returns pins to inputs
		hresetn <= 1'b0;
		@(posedge hclk);
		check("rst pins", d0, 8'h00);
		check("rst oe_n", e0, 8'hFF);
		check("rst p1 oe_n", e1 | 8'h08, 8'hFF);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, PORT1_DRIVE_LEVELS_IDX, 8'h00);
		check("rst p1", rd, 32'h0);
		$display("test unmapped and second reset done");
		conclude();
	end
endmodule
